//--- logic/pmcwp_pkg.sv
package pmcwp_pkg;

    // command codes of the supported registers
    localparam logic [7:0] CODE_OUTPUT_CONTROL = 8'h01;
    localparam logic [7:0] CODE_ENABLE_CONFIG  = 8'h02;
    localparam logic [7:0] CODE_CLEAR_FAULTS   = 8'h03;
    localparam logic [7:0] CODE_WRITE_LOCK     = 8'h10;

    // output_control layout
    localparam int         OC_ON_BIT    = 7;
    localparam int         OC_VOS_LSB   = 2;
    localparam int         OC_VOS_W     = 4;
    localparam logic [7:0] OC_WR_MASK   = 8'hBC;
    localparam logic [7:0] OC_RESET     = 8'h00;

    // enable_source_config layout
    localparam int         CFG_CMD_BIT  = 3;
    localparam int         CFG_CPA_BIT  = 1;
    localparam logic [7:0] CFG_WR_MASK  = 8'h1E;
    localparam logic [7:0] CFG_RESET    = 8'h17;

    // write_lock layout
    localparam int         WL_ALL_BIT   = 7;
    localparam int         WL_OP_BIT    = 6;
    localparam int         WL_CFG_BIT   = 5;
    localparam logic [7:0] WL_WR_MASK   = 8'hE0;
    localparam logic [7:0] WL_RESET     = 8'h00;

    // fault flag byte; bit 1 is the communication fault
    localparam int         FLT_CML_BIT  = 1;
    localparam logic [7:0] FLT_RESET    = 8'h00;
    localparam logic [7:0] FLT_CML_MASK = 8'h02;

    // one decoded command from the link engine
    typedef struct packed {
        logic       write;
        logic [7:0] code;
        logic [7:0] data;
    } pmcwp_req_s;

endpackage : pmcwp_pkg

//--- logic/pmcwp_regs.sv
`timescale 1ns/1ps
// Function
// - output control register, on bit, offset select
// - enable config register at 02, reset 17
// - clear faults command clears set flags
// - clear faults releases the alert line
// - write lock at 10, bits 7:5 only
// - bit5 locks all but lock, control, config
// - bit6 locks all but lock and control
// - bit7 locks everything except lock itself
// - clear lock bit imposes no restriction
module pmcwp_regs
    import pmcwp_pkg::*;
#(
    parameter logic [7:0] CFG_DEFAULT = CFG_RESET,
    parameter logic [7:0] WL_DEFAULT  = WL_RESET
) (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // decoded command port
    input  wire logic       req_valid_in,
    input  wire pmcwp_req_s req_in,
    output logic            rd_valid_out,
    output logic [7:0]      rd_data_out,
    // fault sources, one-cycle events
    input  wire logic [7:0] fault_event_in,
    output logic [7:0]      fault_flags_out,
    // alert pin, open drain, driven low when enabled
    output logic            alert_n_o_out,
    output logic            alert_n_oe_out,
    // control to the regulator
    output logic [7:0]      output_control_out,
    output logic [7:0]      enable_config_out,
    output logic [7:0]      write_lock_out
);

    // write permission for a code under a lock setting
    function automatic logic wr_allowed(input logic [7:0] code,
                                        input logic [7:0] wl);
        logic ok;
        ok = 1'b1;
        if (wl[WL_ALL_BIT] && code != CODE_WRITE_LOCK) begin
            ok = 1'b0;
        end
        if (wl[WL_OP_BIT] && code != CODE_WRITE_LOCK
            && code != CODE_OUTPUT_CONTROL) begin
            ok = 1'b0;
        end
        if (wl[WL_CFG_BIT] && code != CODE_WRITE_LOCK
            && code != CODE_OUTPUT_CONTROL
            && code != CODE_ENABLE_CONFIG) begin
            ok = 1'b0;
        end
        return ok;
    endfunction : wr_allowed

    // code is one of the commands this block answers
    function automatic logic supported(input logic [7:0] code);
        return code == CODE_OUTPUT_CONTROL || code == CODE_ENABLE_CONFIG
            || code == CODE_CLEAR_FAULTS || code == CODE_WRITE_LOCK;
    endfunction : supported

    // register state, next values and decode strobes
    logic [7:0] oc_q, oc_d;
    logic [7:0] cfg_q, cfg_d;
    logic [7:0] wl_q, wl_d;
    logic [7:0] flt_q, flt_d;
    logic       alert_q, alert_d;
    logic       rdv_q, rdv_d;
    logic [7:0] rdd_q, rdd_d;
    logic       wr_go;
    logic       clr_go;
    logic       bad;

    // command decode and next register values
    always_comb begin
        oc_d   = oc_q;
        cfg_d  = cfg_q;
        wl_d   = wl_q;
        rdv_d  = 1'b0;
        rdd_d  = rdd_q;
        wr_go  = req_valid_in && req_in.write
                 && wr_allowed(req_in.code, wl_q);
        clr_go = wr_go && req_in.code == CODE_CLEAR_FAULTS;
        bad    = req_valid_in && (!supported(req_in.code)
                 || (req_in.write && !wr_allowed(req_in.code, wl_q)));
        if (wr_go) begin
            unique case (req_in.code)
                CODE_OUTPUT_CONTROL: oc_d  = req_in.data & OC_WR_MASK;
                CODE_ENABLE_CONFIG:  cfg_d = (cfg_q & ~CFG_WR_MASK)
                                     | (req_in.data & CFG_WR_MASK);
                CODE_WRITE_LOCK:     wl_d  = req_in.data & WL_WR_MASK;
                default: ;
            endcase
        end
        if (req_valid_in && !req_in.write && supported(req_in.code)) begin
            rdv_d = 1'b1;
            unique case (req_in.code)
                CODE_OUTPUT_CONTROL: rdd_d = oc_q;
                CODE_ENABLE_CONFIG:  rdd_d = cfg_q;
                CODE_WRITE_LOCK:     rdd_d = wl_q;
                default:             rdd_d = 8'h00;
            endcase
        end
        // a fresh event in the clearing cycle survives the clear
        flt_d = (clr_go ? FLT_RESET : flt_q) | fault_event_in
                | (bad ? FLT_CML_MASK : FLT_RESET);
        // pin follows the next flags, so it moves with the flag byte
        alert_d = |flt_d;
    end

    // state registers; lock and config start at their stored defaults
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            oc_q    <= OC_RESET;
            cfg_q   <= CFG_DEFAULT;
            wl_q    <= WL_DEFAULT;
            flt_q   <= FLT_RESET;
            alert_q <= 1'b0;
            rdv_q   <= 1'b0;
            rdd_q   <= 8'h00;
        end else begin
            oc_q    <= oc_d;
            cfg_q   <= cfg_d;
            wl_q    <= wl_d;
            flt_q   <= flt_d;
            alert_q <= alert_d;
            rdv_q   <= rdv_d;
            rdd_q   <= rdd_d;
        end
    end

    // outputs straight from flops, except alert_n_o_out which is tied low
    assign output_control_out = oc_q;
    assign enable_config_out  = cfg_q;
    assign write_lock_out     = wl_q;
    assign fault_flags_out    = flt_q;
    assign alert_n_o_out      = 1'b0;   // open drain only ever pulls low
    assign alert_n_oe_out     = alert_q;
    assign rd_valid_out       = rdv_q;
    assign rd_data_out        = rdd_q;

    // checks
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_lock_all_blocks: assert property (
        req_valid_in && req_in.write && wl_q[WL_ALL_BIT]
        && req_in.code == CODE_OUTPUT_CONTROL |=> $stable(oc_q))
        else $error("write passed full lock");
    a_lock_op_only: assert property (
        req_valid_in && req_in.write && wl_q == 8'h40
        && req_in.code == CODE_OUTPUT_CONTROL
        |=> oc_q == ($past(req_in.data) & OC_WR_MASK))
        else $error("control write refused under bit6");
    a_lock_cfg_ok: assert property (
        req_valid_in && req_in.write && wl_q == 8'h20
        && req_in.code == CODE_ENABLE_CONFIG
        |=> cfg_q[CFG_CMD_BIT] == $past(req_in.data[CFG_CMD_BIT]))
        else $error("config write refused under bit5");
    a_lock_op_cfg: assert property (
        req_valid_in && req_in.write && wl_q[WL_OP_BIT]
        && req_in.code == CODE_ENABLE_CONFIG |=> $stable(cfg_q))
        else $error("config written under bit6");
    a_unlocked_write: assert property (
        req_valid_in && req_in.write && wl_q == 8'h00
        && req_in.code == CODE_ENABLE_CONFIG
        |=> cfg_q[CFG_CPA_BIT] == $past(req_in.data[CFG_CPA_BIT]))
        else $error("unlocked write lost");
    a_block_flags: assert property (
        req_valid_in && req_in.write && wl_q[WL_ALL_BIT]
        && req_in.code == CODE_ENABLE_CONFIG
        |=> flt_q[FLT_CML_BIT] ##1 alert_n_oe_out)
        else $error("blocked write not flagged");
    // a clear only counts when no lock bit refuses it
    a_clear_release: assert property (
        req_valid_in && req_in.write && req_in.code == CODE_CLEAR_FAULTS
        && wl_q[WL_ALL_BIT:WL_CFG_BIT] == 3'b000
        && fault_event_in == 8'h00
        |=> !alert_n_oe_out)
        else $error("alert kept after clear");
    a_clear_faults: assert property (
        req_valid_in && req_in.write && req_in.code == CODE_CLEAR_FAULTS
        && wl_q[WL_ALL_BIT:WL_CFG_BIT] == 3'b000
        |=> flt_q == $past(fault_event_in))
        else $error("faults not cleared");
    a_fixed_bits: assert property (
        cfg_q[0] == CFG_DEFAULT[0] && oc_q[6] == 1'b0
        && wl_q[4:0] == 5'h00)
        else $error("read-only bits changed");
    a_vout_offset_select_write: assert property (
        req_valid_in && req_in.write && wl_q == 8'h00
        && req_in.code == CODE_OUTPUT_CONTROL
        |=> oc_q[OC_VOS_LSB +: OC_VOS_W]
            == $past(req_in.data[OC_VOS_LSB +: OC_VOS_W]))
        else $error("offset select not stored");
    // an event in the clearing cycle must outlive the clear
    a_event_wins: assert property (
        clr_go && fault_event_in != 8'h00
        |=> (flt_q & $past(fault_event_in)) == $past(fault_event_in))
        else $error("event lost in clear");
    // reads answer one cycle later with the stored byte
    a_read_answer: assert property (
        req_valid_in && !req_in.write && req_in.code == CODE_OUTPUT_CONTROL
        |=> rd_valid_out && rd_data_out == $past(oc_q))
        else $error("read answer wrong");
    a_lock_masked: assert property (
        req_valid_in && req_in.write && req_in.code == CODE_WRITE_LOCK
        |=> wl_q == ($past(req_in.data) & WL_WR_MASK))
        else $error("lock byte not masked");
    // unknown codes get no answer, only the communication flag
    a_unsupported_flag: assert property (
        req_valid_in && !supported(req_in.code)
        |=> flt_q[FLT_CML_BIT] && !rd_valid_out)
        else $error("unsupported command not flagged");

    c_locked_reject: cover property (
        req_valid_in && req_in.write && wl_q[WL_ALL_BIT]
        && req_in.code != CODE_WRITE_LOCK);
    c_clear_alert: cover property (
        alert_n_oe_out ##1 clr_go ##2 !alert_n_oe_out);
    c_read_back: cover property (rd_valid_out && rd_data_out != 8'h00);
    // set and clear meeting in one cycle, and a write let through by bit5
    c_event_in_clear: cover property (
        clr_go && fault_event_in != 8'h00);
    c_cfg_under_bit5: cover property (
        wr_go && wl_q[WL_CFG_BIT] && req_in.code == CODE_ENABLE_CONFIG);

endmodule : pmcwp_regs

//--- tb/pmcwp_host.sv
`timescale 1ns/1ps
// host model: one command per call, changed off the falling edge
module pmcwp_host
    import pmcwp_pkg::*;
(
    // clock
    input  wire logic  clk_in,
    // command toward the block
    output logic       req_valid_out,
    output pmcwp_req_s req_out
);
    // idle state before the first command
    initial begin
        req_valid_out = 1'b0;
        req_out       = '0;
    end
    // valid for one rising edge; then scrambled so stale data never passes
    task automatic send(input logic wr, input logic [7:0] code,
                        input logic [7:0] data);
        @(negedge clk_in);
        req_valid_out = 1'b1;
        req_out       = '{wr, code, data};
        @(negedge clk_in);
        req_valid_out = 1'b0;
        req_out       = ~req_out;
    endtask : send
endmodule : pmcwp_host

//--- tb/pmcwp_regs_tb.sv
`timescale 1ns/1ps
module pmcwp_regs_tb;
    import pmcwp_pkg::*;
    logic       clk_in;
    logic       rst_n_in;
    logic [7:0] fault_event_in;
    logic       req_valid;
    pmcwp_req_s req;
    logic       rd_valid, oe, alert_o;
    logic [7:0] rd_data, flags, ctl, cfg, lock;
    int         err_total = 0;
    int         checks_done = 0;
    int         cyc = 0;
    logic [7:0] wl [3] = '{8'h20, 8'h40, 8'h80};

    pmcwp_host u_host (.clk_in(clk_in), .req_valid_out(req_valid),
                       .req_out(req));
    pmcwp_regs DUT (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .req_valid_in(req_valid), .req_in(req), .rd_valid_out(rd_valid),
        .rd_data_out(rd_data), .fault_event_in(fault_event_in),
        .fault_flags_out(flags), .alert_n_o_out(alert_o),
        .alert_n_oe_out(oe),
        .output_control_out(ctl), .enable_config_out(cfg),
        .write_lock_out(lock));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        if (err_total == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish

    // writable bits only; read-only bits must not follow the data
    task automatic t_masks();
        send_chk(8'h00, 8'h17, 8'h00);
        u_host.send(1'b1, CODE_OUTPUT_CONTROL, 8'hFF);
        check(ctl, 8'hBC);
        u_host.send(1'b0, CODE_OUTPUT_CONTROL, 8'h00);
        check(rd_data, 8'hBC);
        u_host.send(1'b1, CODE_ENABLE_CONFIG, 8'h00);
        check(cfg, 8'h01);
        u_host.send(1'b1, CODE_WRITE_LOCK, 8'h9F);
        check(lock, 8'h80);
        u_host.send(1'b0, CODE_WRITE_LOCK, 8'h00);
        check(rd_data, 8'h80);
        u_host.send(1'b1, CODE_WRITE_LOCK, 8'h00);
        u_host.send(1'b0, CODE_ENABLE_CONFIG, 8'h00);
        check({7'h00, rd_valid}, 8'h01);
        check(rd_data, 8'h01);
        u_host.send(1'b1, CODE_ENABLE_CONFIG, 8'h17);
        u_host.send(1'b1, CODE_OUTPUT_CONTROL, 8'h00);
    endtask : t_masks

    // reset state of the registers and the alert pin
    task automatic send_chk(input logic [7:0] c, input logic [7:0] g,
                            input logic [7:0] l);
        check(ctl, c);
        check(cfg, g);
        check(lock, l);
        check({flags[7:1], oe}, 8'h00);
        check({7'h00, alert_o}, 8'h00);
    endtask : send_chk

    // each lock bit alone; the host never sets two at once
    task automatic t_lock();
        for (int i = 0; i < 3; i++) begin
            u_host.send(1'b1, CODE_WRITE_LOCK, wl[i]);
            check(lock, wl[i]);
            u_host.send(1'b1, CODE_ENABLE_CONFIG, 8'h15);
            check(cfg, (i == 0) ? 8'h15 : 8'h17);
            check(flags, (i == 0) ? 8'h00 : FLT_CML_MASK);
            u_host.send(1'b1, CODE_OUTPUT_CONTROL, 8'h80);
            check(ctl, (i < 2) ? 8'h80 : 8'h00);
            u_host.send(1'b1, CODE_CLEAR_FAULTS, 8'h00);
            check(flags, FLT_CML_MASK);
            u_host.send(1'b1, CODE_WRITE_LOCK, 8'h00);
            u_host.send(1'b1, CODE_CLEAR_FAULTS, 8'h00);
            check(flags, 8'h00);
            u_host.send(1'b1, CODE_ENABLE_CONFIG, 8'h17);
            u_host.send(1'b1, CODE_OUTPUT_CONTROL, 8'h00);
            send_chk(8'h00, 8'h17, 8'h00);
        end
    endtask : t_lock

    // raise faults, see the alert, then clear both
    task automatic t_clear();
        @(negedge clk_in);
        fault_event_in = 8'h24;
        @(negedge clk_in);
        fault_event_in = 8'h00;
        check(flags, 8'h24);
        @(negedge clk_in);
        check({7'h00, oe}, 8'h01);
        u_host.send(1'b0, 8'h20, 8'h00);
        check({7'h00, rd_valid}, 8'h00);
        check(flags, 8'h26);
        u_host.send(1'b1, CODE_CLEAR_FAULTS, 8'h5A);
        check(flags, 8'h00);
        @(negedge clk_in);
        check({7'h00, oe}, 8'h00);
        // an event landing in the clearing cycle survives it
        fork
            u_host.send(1'b1, CODE_CLEAR_FAULTS, 8'h00);
            begin
                @(negedge clk_in);
                fault_event_in = 8'h08;
                @(negedge clk_in);
                fault_event_in = 8'h00;
            end
        join
        check(flags, 8'h08);
        check({7'h00, oe}, 8'h01);
    endtask : t_clear

    // mid-run reset returns every register and the pin to defaults
    task automatic t_reset();
        u_host.send(1'b1, CODE_WRITE_LOCK, 8'h40);
        u_host.send(1'b1, CODE_ENABLE_CONFIG, 8'h00);
        check(flags, 8'h0A);
        @(negedge clk_in);
        rst_n_in = 1'b0;
        repeat (2) @(negedge clk_in);
        rst_n_in = 1'b1;
        send_chk(8'h00, 8'h17, 8'h00);
        check({7'h00, rd_valid}, 8'h00);
    endtask : t_reset

    // 100 MHz clock
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    // hang guard; the whole run needs well under a thousand cycles
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            tally_and_finish();
        end
    end
    // main sequence
    initial begin
        rst_n_in       = 1'b0;
        fault_event_in = 8'h00;
        repeat (12) @(posedge clk_in);
        @(negedge clk_in);
        rst_n_in = 1'b1;
        t_masks();
        t_lock();
        t_clear();
        t_reset();
        tally_and_finish();
    end
endmodule : pmcwp_regs_tb
